//--- hdl/float_to_fixed_truncation.sv
// Float-to-fixed truncation stage: decode, convert, write back, flag and trap.
// Assumes the decoder presents one instruction per i_issue pulse with the
// source float register value already read onto i_src_operand.
//
// Functional notes
// - Long truncation: coprocessor opcode, long function code, bits 20..16 zero.
// - Word truncation: same opcode, its own function code.
// - Long variant gives a 64-bit signed integer, fraction dropped toward zero.
// - Word variant gives a 32-bit signed integer, always toward zero.
// - Infinity, NaN or out-of-range truncated value is an invalid operation.
// - An invalid operation sets the invalid flag of the control/status register.
// - With invalid enable set, no write and immediate invalid exception.
// - With invalid enable clear, write the largest positive integer of the width.
// - Conversion may signal unimplemented, invalid, overflow and inexact; this stage raises only invalid and inexact.
// - Coprocessor-unusable when unit disabled; reserved-instruction for bad encodings.
`timescale 1ns/1ns
`default_nettype none
module float_to_fixed_truncation
  import float_trunc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_issue,
  input wire logic [31:0] i_instr,
  input wire logic [63:0] i_src_operand,
  input wire logic i_fpu_enable,
  input wire logic i_invalid_enable,
  output logic o_wr_en,
  output logic [4:0] o_dest_float_reg,
  output logic [63:0] o_wr_data,
  output logic o_flag_invalid,
  output logic o_flag_inexact,
  output logic o_exc_invalid,
  output logic o_exc_unusable,
  output logic o_exc_reserved
);

  // ==========================================================
  // Decode
  logic opc_hit;
  logic is_long;
  logic is_word;
  logic fmt_ok;
  logic zero_ok;
  logic is_double;
  logic [4:0] fmt;
  logic [63:0] conv_value;
  logic conv_invalid;
  logic conv_inexact;
  trunc_state_t state_r;
  trunc_state_t state_nxt;

  assign fmt = field5(i_instr, FMT_LSB);
  assign opc_hit = (i_instr[OPC_LSB +: 6] == FLOAT_COPROCESSOR_OPCODE);
  assign is_long = opc_hit && (i_instr[5:0] == FUNCT_TRUNCATE_TO_LONG);
  assign is_word = opc_hit && (i_instr[5:0] == FUNCT_TRUNCATE_TO_WORD);
  assign zero_ok = (field5(i_instr, ZERO_LSB) == ZERO_FIELD);
  assign is_double = (fmt == FMT_DOUBLE);
  assign fmt_ok = (fmt == FMT_SINGLE) || is_double;

  // ==========================================================
  // Conversion
  trunc_core u_core (
    .i_operand(i_src_operand),
    .i_is_double(is_double),
    .i_to_long(is_long),
    .o_value(conv_value),
    .o_invalid(conv_invalid),
    .o_inexact(conv_inexact)
  );

  // ==========================================================
  // Write back, flags and exceptions
  always_comb
  begin
    state_nxt = '0;
    state_nxt.wr_reg = state_r.wr_reg;
    if (i_issue && (is_long || is_word))
    begin
      state_nxt.wr_reg = field5(i_instr, FD_LSB);
      if (!i_fpu_enable)
        state_nxt.exc_unusable = 1'b1;
      else if (!fmt_ok || !zero_ok)
        state_nxt.exc_reserved = 1'b1;
      else if (conv_invalid)
      begin
        state_nxt.flag_invalid = 1'b1;
        state_nxt.exc_invalid = i_invalid_enable;
        state_nxt.wr_en = !i_invalid_enable;
        state_nxt.wr_data = conv_value;
      end
      else
      begin
        state_nxt.wr_en = 1'b1;
        state_nxt.wr_data = conv_value;
        state_nxt.flag_inexact = conv_inexact;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign o_wr_en = state_r.wr_en;
  assign o_dest_float_reg = state_r.wr_reg;
  assign o_wr_data = state_r.wr_data;
  assign o_flag_invalid = state_r.flag_invalid;
  assign o_flag_inexact = state_r.flag_inexact;
  assign o_exc_invalid = state_r.exc_invalid;
  assign o_exc_unusable = state_r.exc_unusable;
  assign o_exc_reserved = state_r.exc_reserved;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  logic ok_issue;
  assign ok_issue = i_issue && i_fpu_enable && fmt_ok && zero_ok;

  property p_long_decode;
    (ok_issue && is_long) |=> (o_wr_en || o_exc_invalid);
  endproperty
  a_long_decode: assert property (p_long_decode)
    else $error("long truncation not executed");

  property p_word_decode;
    (ok_issue && is_word) |=> (o_wr_en || o_exc_invalid);
  endproperty
  a_word_decode: assert property (p_word_decode)
    else $error("word truncation not executed");

  property p_long_one;
    (ok_issue && is_long && is_double && (i_src_operand == 64'h3ff8_0000_0000_0000))
      |=> (o_wr_en && (o_wr_data == 64'h0000_0000_0000_0001));
  endproperty
  a_long_one: assert property (p_long_one)
    else $error("1.5 did not truncate to 1");

  property p_word_neg;
    (ok_issue && is_word && !is_double && (i_src_operand[31:0] == 32'hc020_0000))
      |=> (o_wr_en && (o_wr_data == 64'h0000_0000_ffff_fffe));
  endproperty
  a_word_neg: assert property (p_word_neg)
    else $error("-2.5 did not truncate to -2");

  property p_inf_invalid;
    (ok_issue && (is_long || is_word) && is_double && (i_src_operand[62:52] == EXP_MAX_DOUBLE))
      |=> o_flag_invalid;
  endproperty
  a_inf_invalid: assert property (p_inf_invalid)
    else $error("infinity or NaN not invalid");

  property p_exc_flag;
    o_exc_invalid |-> o_flag_invalid;
  endproperty
  a_exc_flag: assert property (p_exc_flag)
    else $error("invalid exception without flag");

  property p_trap_nowrite;
    (ok_issue && (is_long || is_word) && conv_invalid && i_invalid_enable)
      |=> (o_exc_invalid && !o_wr_en);
  endproperty
  a_trap_nowrite: assert property (p_trap_nowrite)
    else $error("trapped conversion wrote a result");

  property p_default_result;
    (ok_issue && (is_long || is_word) && conv_invalid && !i_invalid_enable)
      |=> (o_wr_en && (o_wr_data == ($past(is_long) ? LONG_MAX : WORD_MAX)));
  endproperty
  a_default_result: assert property (p_default_result)
    else $error("wrong default result");

  property p_inexact;
    o_flag_inexact |-> (o_wr_en && !o_flag_invalid);
  endproperty
  a_inexact: assert property (p_inexact)
    else $error("inexact without clean write");

  property p_unusable;
    (i_issue && (is_long || is_word) && !i_fpu_enable)
      |=> (o_exc_unusable && !o_wr_en && !o_flag_invalid);
  endproperty
  a_unusable: assert property (p_unusable)
    else $error("disabled unit did not raise unusable");

  property p_bad_fmt;
    (i_issue && (is_long || is_word) && i_fpu_enable && !fmt_ok) |=> (o_exc_reserved && !o_wr_en);
  endproperty
  a_bad_fmt: assert property (p_bad_fmt)
    else $error("unsupported format not reserved");

  property p_zero_field;
    (i_issue && (is_long || is_word) && i_fpu_enable && !zero_ok)
      |=> (o_exc_reserved && !o_wr_en);
  endproperty
  a_zero_field: assert property (p_zero_field)
    else $error("nonzero bits 20..16 not reserved");

  property p_word_upper;
    (i_issue && is_word) |=> ((o_wr_data & ~WORD_MASK) == 64'h0);
  endproperty
  a_word_upper: assert property (p_word_upper)
    else $error("word result wider than 32 bits");

  property p_quiet;
    !(i_issue && (is_long || is_word))
      |=> !(o_wr_en || o_flag_invalid || o_exc_invalid || o_exc_unusable || o_exc_reserved);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("output without a truncation issued");

  c_trap: cover property (o_exc_invalid);
  c_default: cover property (o_flag_invalid && o_wr_en);
  c_inexact: cover property (o_flag_inexact);
  c_reserved: cover property (o_exc_reserved);
  c_unusable: cover property (o_exc_unusable);

endmodule // float_to_fixed_truncation
`default_nettype wire

//--- hdl/float_trunc_pkg.sv
// Constants and carriers for the float-to-fixed truncation datapath.
// Assumes instruction words and float register contents arrive as 32 and 64 bits.
package float_trunc_pkg;

  // ==========================================================
  // Instruction encoding
  localparam logic [5:0] FLOAT_COPROCESSOR_OPCODE = 6'h11;
  localparam logic [5:0] FUNCT_TRUNCATE_TO_LONG = 6'h09;
  localparam logic [5:0] FUNCT_TRUNCATE_TO_WORD = 6'h0d;
  localparam logic [4:0] FMT_SINGLE = 5'h10;
  localparam logic [4:0] FMT_DOUBLE = 5'h11;
  localparam logic [4:0] ZERO_FIELD = 5'h00;
  localparam int OPC_LSB = 26;
  localparam int FMT_LSB = 21;
  localparam int ZERO_LSB = 16;
  localparam int FS_LSB = 11;
  localparam int FD_LSB = 6;

  // ==========================================================
  // Number formats
  localparam logic signed [12:0] BIAS_DOUBLE = 13'sh03ff;
  localparam logic signed [12:0] BIAS_SINGLE = 13'sh007f;
  localparam logic signed [12:0] MANT_TOP = 13'sh0034;
  localparam logic signed [12:0] LONG_TOP = 13'sh003f;
  localparam logic [10:0] EXP_MAX_DOUBLE = 11'h7ff;
  localparam logic [7:0] EXP_MAX_SINGLE = 8'hff;
  localparam logic [63:0] LONG_MAX = 64'h7fff_ffff_ffff_ffff;
  localparam logic [63:0] WORD_MAX = 64'h0000_0000_7fff_ffff;
  localparam logic [63:0] LONG_LIMIT = 64'h8000_0000_0000_0000;
  localparam logic [63:0] WORD_LIMIT = 64'h0000_0000_8000_0000;
  localparam logic [63:0] WORD_MASK = 64'h0000_0000_ffff_ffff;

  // ==========================================================
  // Registered state of the datapath
  typedef struct packed {
    logic wr_en;
    logic [4:0] wr_reg;
    logic [63:0] wr_data;
    logic flag_invalid;
    logic flag_inexact;
    logic exc_invalid;
    logic exc_unusable;
    logic exc_reserved;
  } trunc_state_t;

  function automatic logic [4:0] field5(input logic [31:0] instr, input int lsb);
    field5 = instr[lsb +: 5];
  endfunction

endpackage

//--- hdl/trunc_core.sv
// Combinational truncation of a single or double value to a long or word.
// Assumes single operands sit in the low 32 bits of the 64-bit operand.
`timescale 1ns/1ns
`default_nettype none
module trunc_core
  import float_trunc_pkg::*;
(
  input wire logic [63:0] i_operand,
  input wire logic i_is_double,
  input wire logic i_to_long,
  output logic [63:0] o_value,
  output logic o_invalid,
  output logic o_inexact
);

  logic sign;
  logic special;
  logic big;
  logic lost;
  logic over;
  logic [10:0] expf;
  logic [52:0] mant;
  logic signed [12:0] e;
  logic signed [12:0] sh;
  logic [63:0] mag;
  logic [63:0] limit;

  always_comb
  begin
    if (i_is_double)
    begin
      sign = i_operand[63];
      expf = i_operand[62:52];
      mant = {(expf != 11'h000), i_operand[51:0]};
      special = (expf == EXP_MAX_DOUBLE);
      e = $signed({2'b00, expf}) - BIAS_DOUBLE;
    end
    else
    begin
      sign = i_operand[31];
      expf = {3'h0, i_operand[30:23]};
      mant = {(expf != 11'h000), i_operand[22:0], 29'h0};
      special = (i_operand[30:23] == EXP_MAX_SINGLE);
      e = $signed({2'b00, expf}) - BIAS_SINGLE;
    end
    big = 1'b0;
    lost = 1'b0;
    mag = 64'h0;
    sh = MANT_TOP - e;
    // Fraction bits below the point are dropped: round toward zero
    if (e < 13'sh0000)
      lost = |mant;
    else if (e <= MANT_TOP)
    begin
      mag = {11'h000, mant} >> sh[5:0];
      lost = |(mant & ~({53{1'b1}} << sh[5:0]));
    end
    else if (e <= LONG_TOP)
      mag = {11'h000, mant} << 6'(e - MANT_TOP);
    else
      big = 1'b1;
    limit = i_to_long ? LONG_LIMIT : WORD_LIMIT;
    over = big | (sign ? (mag > limit) : (mag >= limit));
    o_invalid = special | over;
    o_inexact = lost & ~o_invalid;
    if (o_invalid)
      o_value = i_to_long ? LONG_MAX : WORD_MAX;
    else if (i_to_long)
      o_value = sign ? (64'h0 - mag) : mag;
    else
      o_value = (sign ? (64'h0 - mag) : mag) & WORD_MASK;
  end

endmodule // trunc_core
`default_nettype wire

//--- verification/float_reg_model.sv
// Model of the decoder and float register file feeding the truncation stage.
// Assumes the bench preloads source registers by hierarchical write.
`timescale 1ns/1ns
`default_nettype none
module float_reg_model
(
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [31:0] i_instr,
  input wire logic i_wr_en,
  input wire logic [4:0] i_wr_reg,
  input wire logic [63:0] i_wr_data,
  output logic o_issue,
  output logic [31:0] o_instr,
  output logic [63:0] o_operand
);
  // ==========================================================
  // Register file
  logic [63:0] regs [32];
  logic [63:0] rd_val;

  assign rd_val = regs[i_instr[15:11]];
  assign o_issue = i_req;
  assign o_instr = i_instr;
  // Operand valid only while issuing
  assign o_operand = i_req ? rd_val : ~rd_val;

  always @(posedge i_clk)
  begin
    if (i_wr_en)
      regs[i_wr_reg] <= i_wr_data;
  end
endmodule // float_reg_model
`default_nettype wire

//--- verification/tb_float_to_fixed_truncation.sv
// Self-checking bench for the float-to-fixed truncation stage.
// Assumes package, core and stage files are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module tb_float_to_fixed_truncation
  import float_trunc_pkg::*;
;
  localparam logic [5:0] LG = FUNCT_TRUNCATE_TO_LONG;
  localparam logic [5:0] WD = FUNCT_TRUNCATE_TO_WORD;
  localparam logic [4:0] DB = FMT_DOUBLE;
  localparam logic [4:0] SG = FMT_SINGLE;
  localparam logic [63:0] ONE5 = 64'h3ff8000000000000;
  logic clk;
  logic nrst;
  logic req;
  logic [31:0] instr;
  logic fpu_en;
  logic inv_en;
  logic [4:0] nfd = 5'h00;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  wire issue;
  wire [31:0] instr_q;
  wire [63:0] operand;
  wire wr_en;
  wire [4:0] dest;
  wire [63:0] wr_data;
  wire [4:0] flags;

  // ==========================================================
  // Instances
  float_reg_model i_model
  (
    .i_clk(clk),
    .i_req(req),
    .i_instr(instr),
    .i_wr_en(wr_en),
    .i_wr_reg(dest),
    .i_wr_data(wr_data),
    .o_issue(issue),
    .o_instr(instr_q),
    .o_operand(operand)
  );
  float_to_fixed_truncation i_dut
  (
    .i_clk(clk),
    .i_nrst(nrst),
    .i_issue(issue),
    .i_instr(instr_q),
    .i_src_operand(operand),
    .i_fpu_enable(fpu_en),
    .i_invalid_enable(inv_en),
    .o_wr_en(wr_en),
    .o_dest_float_reg(dest),
    .o_wr_data(wr_data),
    .o_flag_invalid(flags[4]),
    .o_flag_inexact(flags[3]),
    .o_exc_invalid(flags[2]),
    .o_exc_unusable(flags[1]),
    .o_exc_reserved(flags[0])
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] mk(input logic [4:0] fmt, input logic [5:0] fn);
    mk = {FLOAT_COPROCESSOR_OPCODE, fmt, ZERO_FIELD, 5'h1f, nfd, fn};
  endfunction

  task automatic stop_test();
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Issue at a falling edge; result stands for the following cycle
  task automatic op(input logic [31:0] ins, input logic [63:0] val, input logic wen,
                    input logic [63:0] ew, input logic [4:0] ef);
    i_model.regs[31] = val;
    req = 1'b1;
    instr = ins;
    nfd = nfd + 5'h01;
    @(posedge clk);
    @(negedge clk);
    chk("wr_en", {63'h0, wen}, {63'h0, wr_en});
    chk("wr_data", ew, wr_data);
    chk("flags", {59'h0, ef}, {59'h0, flags});
    if (wen)
      chk("dest", {59'h0, ins[10:6]}, {59'h0, dest});
  endtask

  task automatic idle(input string name);
    req = 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("idle_wr", 64'h0, {63'h0, wr_en});
    chk("idle_flags", 64'h0, {59'h0, flags});
    $display("Test %s done", name);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_long();
    fpu_en = 1'b1;
    inv_en = 1'b0;
    op(mk(DB, LG), ONE5, 1'b1, 64'h1, 5'h08);
    op(mk(DB, LG), 64'hc006000000000000, 1'b1, ~64'h1, 5'h08);
    op(mk(DB, LG), 64'hc3e0000000000000, 1'b1, LONG_LIMIT, 5'h00);
    op(mk(SG, LG), 64'h5555555540e00000, 1'b1, 64'h7, 5'h00);
    idle("long");
  endtask

  task automatic t_word();
    op(mk(SG, WD), 64'h40400000, 1'b1, 64'h3, 5'h00);
    op(mk(SG, WD), 64'hbfc00000, 1'b1, WORD_MASK, 5'h08);
    op(mk(SG, WD), 64'hc0200000, 1'b1, 64'hffff_fffe, 5'h08);
    op(mk(DB, WD), 64'hc1e0000000000000, 1'b1, WORD_LIMIT, 5'h00);
    op(mk(DB, WD), 64'h41dfffffffe00000, 1'b1, WORD_MAX, 5'h08);
    idle("word");
  endtask

  task automatic t_default();
    op(mk(DB, LG), 64'h7ff0000000000000, 1'b1, LONG_MAX, 5'h10);
    op(mk(DB, LG), 64'hc3f0000000000000, 1'b1, LONG_MAX, 5'h10);
    op(mk(DB, WD), 64'h41e0000000000000, 1'b1, WORD_MAX, 5'h10);
    op(mk(SG, WD), 64'h7fc00000, 1'b1, WORD_MAX, 5'h10);
    idle("default");
  endtask

  // Trapped results still show the saturated value, with the write held off
  task automatic t_trap();
    inv_en = 1'b1;
    op(mk(DB, LG), 64'h43e0000000000000, 1'b0, LONG_MAX, 5'h14);
    op(mk(SG, WD), 64'hff800000, 1'b0, WORD_MAX, 5'h14);
    op(mk(DB, LG), ONE5, 1'b1, 64'h1, 5'h08);
    idle("trap");
  endtask

  task automatic t_refuse();
    fpu_en = 1'b0;
    inv_en = 1'b0;
    op(mk(DB, LG), ONE5, 1'b0, 64'h0, 5'h02);
    op(mk(5'h14, WD), ONE5, 1'b0, 64'h0, 5'h02);
    fpu_en = 1'b1;
    op(mk(5'h14, WD), ONE5, 1'b0, 64'h0, 5'h01);
    op(mk(DB, LG) | 32'h00010000, ONE5, 1'b0, 64'h0, 5'h01);
    op(mk(DB, 6'h00), ONE5, 1'b0, 64'h0, 5'h00);
    op(mk(DB, LG) ^ 32'h04000000, ONE5, 1'b0, 64'h0, 5'h00);
    idle("refuse");
  endtask

  // ==========================================================
  // Clock, timeout and main sequence
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 500)
    begin
      err_total++;
      stop_test();
    end
  end

  initial
  begin
    nrst = 1'b0;
    req = 1'b0;
    instr = 32'h0;
    fpu_en = 1'b0;
    inv_en = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk("reset_flags", 64'h0, {59'h0, flags});
    t_long();
    t_word();
    t_default();
    t_trap();
    t_refuse();
    stop_test();
  end
endmodule // tb_float_to_fixed_truncation
`default_nettype wire
